// [logic/rtss_defines.vh]
/*
  Constants of the radio telegram subframe scheduler: field
  sizes, copy timing windows in ms and maturity times.
  Assumes the includer runs at the rate given below.
*/
`ifndef RTSS_DEFINES_VH
`define RTSS_DEFINES_VH
// Clock and millisecond base
`define RTSS_CLK_PS        4000
`define RTSS_MS_PS         1000000000
// Telegram buffer
`define RTSS_BUF_DEPTH     32
`define RTSS_LEN_IDX       5'h00
`define RTSS_FIRST_IDX     5'h01
`define RTSS_ID_LONG_N     3'h6
`define RTSS_ID_SHORT_N    3'h4
`define RTSS_TGT_N         3'h4
`define RTSS_SIDE_LSB      0
`define RTSS_SIDE_MSB      3
// Field sequencer steps
`define RTSS_F_HDR         3'h0
`define RTSS_F_EXT         3'h1
`define RTSS_F_LTYPE       3'h2
`define RTSS_F_SRC         3'h3
`define RTSS_F_TGT         3'h4
// Standard windows, ms
`define RTSS_S0_C2_LO      8'h01
`define RTSS_S0_C2_HI      8'h09
`define RTSS_S0_C3_LO      8'h14
`define RTSS_S0_C3_HI      8'h27
`define RTSS_S1_C1_LO      8'h0a
`define RTSS_S1_C1_HI      8'h13
`define RTSS_S2_C1_LO      8'h00
`define RTSS_S2_C1_HI      8'h09
`define RTSS_SR_C2_LO      8'h14
`define RTSS_SR_C2_HI      8'h1d
// Compressed windows, ms
`define RTSS_C_C1_LO       8'h00
`define RTSS_C_C1_HI       8'h01
`define RTSS_C_C2_LO       8'h04
`define RTSS_C_C2_HI       8'h0c
`define RTSS_C_C3_LO       8'h0e
`define RTSS_C_C3_HI       8'h16
// Maturity times, ms
`define RTSS_TXMAT_STD     8'h28
`define RTSS_TXMAT_CMP     8'h19
`define RTSS_RXMAT_STD     8'h64
`define RTSS_RXMAT_CMP     8'h32
// Pseudo-random source
`define RTSS_LFSR_SEED     16'hace1
`endif

// [logic/rtss_scheduler.v]
/*
  Radio telegram framer and copy scheduler, with its payload FIFO.
  Assumes all inputs synchronous to i_ref_clk and a byte sink on the
  radio side that takes a byte when o_tx_valid and i_tx_ready are high.
*/
`timescale 1ns/1ps
`include "rtss_defines.vh"

////////////////////////////////////////////////////////////////////
// Payload FIFO
module rtss_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  // Clock and reset
  input  wire          i_ref_clk,
  input  wire          i_rst_b,
  // Fill side
  input  wire          i_in_valid,
  input  wire [W-1:0]  i_in_data,
  output reg           o_in_ready,
  // Drain side
  output wire          o_out_valid,
  output wire [W-1:0]  o_out_data,
  input  wire          i_out_ready
);
  reg  [W-1:0] mem_q [0:D-1];   // Storage
  reg  [AW-1:0] wr_q;           // Write index
  reg  [AW-1:0] rd_q;           // Read index
  reg  [AW:0]  cnt_q;           // Fill level
  wire         push;
  wire         pop;
  wire [AW:0]  cnt_d;

  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign cnt_d       = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Pointers, level and registered ready
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q       <= {AW{1'b0}};
      rd_q       <= {AW{1'b0}};
      cnt_q      <= {(AW+1){1'b0}};
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == D-1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == D-1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q      <= cnt_d;
      // Ready from the next level keeps it a flop output
      o_in_ready <= (cnt_d != D);
    end
  end

  // Data write, no reset needed for storage
  always @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
endmodule // rtss_fifo

////////////////////////////////////////////////////////////////////
// Framer and scheduler
module rtss_scheduler #(
  parameter integer P_CYC_PER_MS = `RTSS_MS_PS / `RTSS_CLK_PS
) (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  // Transmit command from host
  input  wire        i_tx_req,
  input  wire        i_tx_compressed,
  input  wire [1:0]  i_tx_rep_level,
  input  wire        i_tx_three,
  input  wire        i_tx_single,
  input  wire [7:0]  i_header,
  input  wire        i_hop_hdr_en,
  input  wire [7:0]  i_optional_hop_header,
  input  wire        i_long_type_en,
  input  wire [7:0]  i_long_type_selector,
  input  wire        i_src_long,
  input  wire [47:0] i_source_id,
  input  wire        i_target_en,
  input  wire [31:0] i_target_id,
  input  wire [4:0]  i_pay_len,
  // Payload and side data stream
  input  wire        i_pay_valid,
  input  wire [7:0]  i_pay_data,
  output wire        o_pay_ready,
  // Radio byte stream
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_data,
  output reg         o_tx_start,
  output reg         o_tx_side,
  output reg  [1:0]  o_tx_copy,
  input  wire        i_tx_ready,
  // Transmit status
  output reg         o_tx_busy,
  output reg         o_tx_mature,
  output reg         o_tx_refused,
  // Received copy notice
  input  wire        i_rx_valid,
  input  wire        i_rx_compressed,
  input  wire [47:0] i_rx_source_id,
  input  wire [7:0]  i_rx_check,
  input  wire        i_rx_has_target,
  output reg         o_rx_new,
  output reg         o_rx_dup,
  output reg         o_rx_addressed
);
  // States
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_HDR  = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_CHK  = 3'h3;
  localparam [2:0] S_WAIT = 3'h4;
  localparam [2:0] S_SEND = 3'h5;
  localparam [17:0] PRE_LAST = P_CYC_PER_MS[17:0] - 18'h1;

  reg  [2:0]  st_q;             // Main state
  reg  [7:0]  mem_q [0:`RTSS_BUF_DEPTH-1]; // Telegram image
  reg  [4:0]  wp_q;             // Build index
  reg  [4:0]  rp_q;             // Send index
  reg  [4:0]  last_q;           // Index of check byte
  reg  [4:0]  side_q;           // First side data index
  reg  [4:0]  left_q;           // Stream bytes still to take
  reg  [2:0]  fs_q;             // Field step
  reg  [2:0]  k_q;              // Byte within field
  reg  [7:0]  chk_q;            // Running check
  reg  [47:0] src_q;            // Source id, left aligned
  reg  [31:0] tgt_q;            // Target id shift
  reg  [7:0]  hdr_q;
  reg  [7:0]  hop_q;
  reg  [7:0]  lt_q;
  reg         hop_en_q;
  reg         lt_en_q;
  reg         src6_q;
  reg         tgt_en_q;
  reg         cmp_q;            // Compressed profile
  reg  [2:0]  need_q;           // Copies still owed
  reg  [1:0]  cur_q;            // Copy being sent next
  reg  [7:0]  off_q [0:2];      // Copy offsets, ms
  reg  [17:0] pre_q;            // Millisecond prescaler
  reg  [7:0]  ms_q;             // Ms since request, saturating
  reg  [15:0] lfsr_q;           // Random source
  reg  [47:0] rx_src_q;         // Last merged sender
  reg  [7:0]  rx_chk_q;
  reg  [7:0]  rx_age_q;         // Ms since first copy
  reg         rx_seen_q;
  wire        tick;
  wire        f_ready;
  wire        f_valid;
  wire [7:0]  f_data;
  wire        f_take;
  wire [7:0]  rx_win;
  wire        rx_same;
  wire [7:0]  mat_lim;
  wire [7:0]  hb;               // Header byte being built
  wire [4:0]  side_len;
  integer     i;

  // Uniform draw within lo..hi
  function [7:0] pick;
    input [7:0] lo;
    input [7:0] hi;
    input [7:0] r;
    begin
      pick = lo + (r % (hi - lo + 8'h01));
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Payload FIFO, drained only while building
  assign f_take = (st_q == S_DATA) & (left_q != 5'h00);

  rtss_fifo #(.W(8), .D(8), .AW(3)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (i_pay_valid),
    .i_in_data   (i_pay_data),
    .o_in_ready  (f_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_take)
  );
  assign o_pay_ready = f_ready;

  ////////////////////////////////////////////////////////////////
  // Field selection for the header sequencer
  assign side_len = {1'b0, hop_q[`RTSS_SIDE_MSB:`RTSS_SIDE_LSB]};
  assign hb = (fs_q == `RTSS_F_HDR)   ? hdr_q :
              (fs_q == `RTSS_F_EXT)   ? hop_q :
              (fs_q == `RTSS_F_LTYPE) ? lt_q :
              (fs_q == `RTSS_F_SRC)   ? src_q[47:40] :
              tgt_q[31:24];
  assign tick    = (pre_q == PRE_LAST);
  assign mat_lim = cmp_q ? `RTSS_TXMAT_CMP : `RTSS_TXMAT_STD;

  ////////////////////////////////////////////////////////////////
  // Random source, free running
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lfsr_q <= `RTSS_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0],
                 lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Telegram image writes; data only, left unreset
  always @(posedge i_ref_clk) begin
    if (st_q == S_HDR) begin
      mem_q[wp_q] <= hb;
    end else if (f_take & f_valid) begin
      mem_q[wp_q] <= f_data;
    end else if (st_q == S_CHK) begin
      mem_q[wp_q] <= chk_q ^ {3'h0, wp_q + 5'h01};
      mem_q[`RTSS_LEN_IDX] <= {3'h0, wp_q + 5'h01};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Build, schedule and send
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= S_IDLE;
      wp_q <= `RTSS_FIRST_IDX;
      rp_q <= `RTSS_LEN_IDX;
      last_q <= 5'h00;
      side_q <= 5'h00;
      left_q <= 5'h00;
      fs_q <= `RTSS_F_HDR;
      k_q <= 3'h0;
      chk_q <= 8'h00;
      src_q <= 48'h0;
      tgt_q <= 32'h0;
      hdr_q <= 8'h00;
      hop_q <= 8'h00;
      lt_q <= 8'h00;
      hop_en_q <= 1'b0;
      lt_en_q <= 1'b0;
      src6_q <= 1'b0;
      tgt_en_q <= 1'b0;
      cmp_q <= 1'b0;
      need_q <= 3'h0;
      cur_q <= 2'h0;
      for (i = 0; i < 3; i = i + 1) begin
        off_q[i] <= 8'h00;
      end
      pre_q <= 18'h0;
      ms_q <= 8'h00;
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_start <= 1'b0;
      o_tx_side <= 1'b0;
      o_tx_copy <= 2'h0;
      o_tx_busy <= 1'b0;
      o_tx_mature <= 1'b0;
      o_tx_refused <= 1'b0;
    end else begin
      o_tx_refused <= 1'b0;
      // Ms base restarts with each accepted request
      pre_q <= tick ? 18'h0 : pre_q + 18'h1;
      if (tick && ms_q != 8'hff) begin
        ms_q <= ms_q + 8'h01;
      end
      // Mature once window passed and nothing owed
      if (o_tx_busy == 1'b0 && ms_q >= mat_lim) begin
        o_tx_mature <= 1'b1;
      end
      case (st_q)
        S_IDLE: begin
          if (i_tx_req) begin
            if (i_tx_compressed && i_tx_rep_level == 2'h2) begin
              o_tx_refused <= 1'b1;
            end else begin
              st_q <= S_HDR;
              o_tx_busy <= 1'b1;
              o_tx_mature <= 1'b0;
              pre_q <= 18'h0;
              ms_q <= 8'h00;
              wp_q <= `RTSS_FIRST_IDX;
              fs_q <= `RTSS_F_HDR;
              k_q <= 3'h0;
              chk_q <= 8'h00;
              cur_q <= 2'h0;
              cmp_q <= i_tx_compressed;
              hdr_q <= i_header;
              hop_q <= i_hop_hdr_en ? i_optional_hop_header : 8'h00;
              hop_en_q <= i_hop_hdr_en;
              lt_q <= i_long_type_selector;
              lt_en_q <= i_long_type_en;
              src6_q <= i_src_long;
              src_q <= i_src_long ? i_source_id : {i_source_id[31:0], 16'h0};
              tgt_q <= i_target_id;
              tgt_en_q <= i_target_en;
              left_q <= i_pay_len;
              // Copy count per type and repeater level
              if (i_tx_single) begin
                need_q <= 3'h1;
              end else if (i_tx_three && i_tx_rep_level == 2'h0) begin
                need_q <= 3'h7;
              end else begin
                need_q <= 3'h3;
              end
              // Offsets per profile and level
              if (i_tx_compressed) begin
                off_q[0] <= pick(`RTSS_C_C1_LO, `RTSS_C_C1_HI, lfsr_q[7:0]);
                off_q[1] <= pick(`RTSS_C_C2_LO, `RTSS_C_C2_HI, lfsr_q[15:8]);
                off_q[2] <= pick(`RTSS_C_C3_LO, `RTSS_C_C3_HI, lfsr_q[11:4]);
              end else if (i_tx_rep_level == 2'h0) begin
                off_q[0] <= 8'h00;
                off_q[1] <= pick(`RTSS_S0_C2_LO, `RTSS_S0_C2_HI, lfsr_q[15:8]);
                off_q[2] <= pick(`RTSS_S0_C3_LO, `RTSS_S0_C3_HI, lfsr_q[11:4]);
              end else if (i_tx_rep_level == 2'h1) begin
                off_q[0] <= pick(`RTSS_S1_C1_LO, `RTSS_S1_C1_HI, lfsr_q[7:0]);
                off_q[1] <= pick(`RTSS_SR_C2_LO, `RTSS_SR_C2_HI, lfsr_q[15:8]);
                off_q[2] <= 8'hff;
              end else begin
                off_q[0] <= pick(`RTSS_S2_C1_LO, `RTSS_S2_C1_HI, lfsr_q[7:0]);
                off_q[1] <= pick(`RTSS_SR_C2_LO, `RTSS_SR_C2_HI, lfsr_q[15:8]);
                off_q[2] <= 8'hff;
              end
            end
          end
        end
        S_HDR: begin
          // One field byte per cycle, skipping absent fields
          chk_q <= chk_q ^ hb;
          wp_q <= wp_q + 5'h01;
          k_q <= 3'h0;
          case (fs_q)
            `RTSS_F_HDR: begin
              fs_q <= hop_en_q ? `RTSS_F_EXT : (lt_en_q ? `RTSS_F_LTYPE : `RTSS_F_SRC);
            end
            `RTSS_F_EXT: begin
              fs_q <= lt_en_q ? `RTSS_F_LTYPE : `RTSS_F_SRC;
            end
            `RTSS_F_LTYPE: begin
              fs_q <= `RTSS_F_SRC;
            end
            `RTSS_F_SRC: begin
              src_q <= {src_q[39:0], 8'h00};
              k_q <= k_q + 3'h1;
              if (k_q == (src6_q ? `RTSS_ID_LONG_N : `RTSS_ID_SHORT_N) - 3'h1) begin
                k_q <= 3'h0;
                fs_q <= `RTSS_F_TGT;
                st_q <= tgt_en_q ? S_HDR : S_DATA;
                side_q <= wp_q + 5'h01 + left_q;
                left_q <= left_q + side_len;
              end
            end
            default: begin
              tgt_q <= {tgt_q[23:0], 8'h00};
              k_q <= k_q + 3'h1;
              if (k_q == `RTSS_TGT_N - 3'h1) begin
                st_q <= S_DATA;
                side_q <= side_q + {2'h0, `RTSS_TGT_N};
              end
            end
          endcase
        end
        S_DATA: begin
          if (left_q == 5'h00) begin
            st_q <= S_CHK;
          end else if (f_valid) begin
            chk_q <= chk_q ^ f_data;
            wp_q <= wp_q + 5'h01;
            left_q <= left_q - 5'h01;
          end
        end
        S_CHK: begin
          last_q <= wp_q;
          st_q <= S_WAIT;
        end
        S_WAIT: begin
          if (need_q == 3'h0) begin
            o_tx_busy <= 1'b0;
            st_q <= S_IDLE;
          end else if (need_q[cur_q] && ms_q >= off_q[cur_q]) begin
            st_q <= S_SEND;
            rp_q <= `RTSS_LEN_IDX;
          end
        end
        S_SEND: begin
          // Load a byte when the sink took the last one
          if (!o_tx_valid || i_tx_ready) begin
            o_tx_start <= 1'b0;
            if (rp_q <= last_q && !(o_tx_valid && rp_q == 5'h00 && !o_tx_start)) begin
              o_tx_valid <= 1'b1;
              o_tx_data <= mem_q[rp_q];
              o_tx_start <= (rp_q == `RTSS_LEN_IDX);
              o_tx_side <= (rp_q >= side_q) && (rp_q < last_q);
              o_tx_copy <= cur_q;
              rp_q <= (rp_q == last_q) ? 5'h00 : rp_q + 5'h01;
            end else begin
              o_tx_valid <= 1'b0;
              o_tx_side <= 1'b0;
              need_q[cur_q] <= 1'b0;
              cur_q <= cur_q + 2'h1;
              st_q <= S_WAIT;
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Receive merging of identical copies
  assign rx_win  = i_rx_compressed ? `RTSS_RXMAT_CMP : `RTSS_RXMAT_STD;
  assign rx_same = rx_seen_q && (rx_src_q == i_rx_source_id) && (rx_chk_q == i_rx_check);

  // Window runs from the first copy, not the latest
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_src_q <= 48'h0;
      rx_chk_q <= 8'h00;
      rx_age_q <= 8'h00;
      rx_seen_q <= 1'b0;
      o_rx_new <= 1'b0;
      o_rx_dup <= 1'b0;
      o_rx_addressed <= 1'b0;
    end else begin
      o_rx_new <= 1'b0;
      o_rx_dup <= 1'b0;
      if (tick && rx_age_q != 8'hff) begin
        rx_age_q <= rx_age_q + 8'h01;
      end
      if (i_rx_valid) begin
        if (rx_same && rx_age_q < rx_win) begin
          o_rx_dup <= 1'b1;
        end else begin
          o_rx_new <= 1'b1;
          o_rx_addressed <= i_rx_has_target;
          rx_src_q <= i_rx_source_id;
          rx_chk_q <= i_rx_check;
          rx_age_q <= 8'h00;
          rx_seen_q <= 1'b1;
        end
      end
    end
  end
endmodule // rtss_scheduler

// [bench/rtss_checker.sv]
/* Port checker of the telegram scheduler.
   Assumes one clock domain and the bind at the foot. */
`timescale 1ns/1ps
module rtss_checker #(
  parameter integer P_CYC_PER_MS = 100
) (
  // Watched ports
  input wire       i_ref_clk,
  input wire       i_rst_b,
  input wire       i_tx_req,
  input wire       i_tx_compressed,
  input wire [1:0] i_tx_rep_level,
  input wire       i_tx_single,
  input wire       i_tx_ready,
  input wire       o_tx_valid,
  input wire [7:0] o_tx_data,
  input wire       o_tx_start,
  input wire [1:0] o_tx_copy,
  input wire       o_tx_busy,
  input wire       o_tx_refused,
  input wire       i_rx_valid,
  input wire       i_rx_has_target,
  input wire       o_rx_new,
  input wire       o_rx_dup,
  input wire       o_rx_addressed
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire       take_w = i_tx_req && !o_tx_busy; // Request while not busy, refused ones included
  wire       bad_w  = i_tx_compressed && (i_tx_rep_level == 2'h2); // Forbidden profile
  reg  [1:0] lvl_q;  // Level of request
  reg        one_q;  // Single copy request
  integer    lim_q;  // Busy bound, cycles
  integer    busy_q; // Busy cycles so far
  ////////////////////////////////////////////////////////////////////
  // Latch the request; slack covers framing and a stalled last copy
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl_q  <= 2'h0;
      one_q  <= 1'b0;
      lim_q  <= 0;
      busy_q <= 0;
    end else if (take_w) begin
      lvl_q  <= i_tx_rep_level;
      one_q  <= i_tx_single;
      lim_q  <= (i_tx_compressed ? 25 : 40) * P_CYC_PER_MS + 128;
      busy_q <= 0;
    end else if (o_tx_busy) begin
      busy_q <= busy_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  a_refuse_pulse: assert property (take_w && bad_w |=> o_tx_refused && !o_tx_busy && !o_tx_valid)
    else $error("forbidden request not refused");
  a_req_busy: assert property (take_w && !bad_w |=> o_tx_busy)
    else $error("request not taken");
  a_byte_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("byte changed before ready");
  a_no_third: assert property (o_tx_valid && (lvl_q != 2'h0) |-> o_tx_copy != 2'h2)
    else $error("repeater sent third copy");
  a_single_one: assert property (o_tx_valid && one_q |-> o_tx_copy == 2'h0)
    else $error("single type sent extra copy");
  a_busy_bound: assert property (o_tx_busy |-> busy_q < lim_q)
    else $error("copies not done in time");
  a_rx_answer: assert property (i_rx_valid |=> o_rx_new != o_rx_dup)
    else $error("received copy not judged");
  a_rx_quiet: assert property (!i_rx_valid |=> !o_rx_new && !o_rx_dup)
    else $error("judgement without copy");
  a_rx_addr: assert property (o_rx_new |-> o_rx_addressed == $past(i_rx_has_target))
    else $error("addressed flag wrong");
  c_refused: cover property (o_tx_refused);
  c_third: cover property (o_tx_valid && o_tx_start && o_tx_copy == 2'h2);
  c_dup: cover property (o_rx_dup);
endmodule // rtss_checker
bind rtss_scheduler rtss_checker #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_chk (.*);

// [bench/rtss_radio_sink.sv]
/* Radio byte sink standing for the transmitter.
   Assumes bytes arrive in copies, each flagged by start. */
`timescale 1ns/1ps
module rtss_radio_sink (
  // Clock, reset and bench control
  input  wire       i_ref_clk,
  input  wire       i_rst_b,
  input  wire       i_stall,
  input  wire       i_clr,
  // Byte stream from the scheduler
  input  wire       i_valid,
  input  wire [7:0] i_data,
  input  wire       i_start,
  input  wire       i_side,
  input  wire [1:0] i_copy,
  output reg        o_ready
);
  reg     [7:0] mem    [0:2][0:31]; // Bytes per copy
  reg           sd     [0:2][0:31]; // Side flags per copy
  integer       cnt    [0:2];       // Byte count per copy
  reg     [1:0] st_cp  [0:2];       // Copy index per start
  integer       st_cyc [0:2];       // Cycle of each start
  integer       n_st;               // Copies started
  integer       cyc;                // Free cycle count
  integer       i;
  // Stall halves the rate, so the scheduler must hold each byte
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b0;
      cyc     <= 0;
      n_st    <= 0;
    end else begin
      cyc     <= cyc + 1;
      o_ready <= i_stall ? !o_ready : 1'b1;
      if (i_clr) begin
        n_st <= 0;
        for (i = 0; i < 3; i = i + 1) cnt[i] <= 0;
      end else if (i_valid && o_ready) begin
        mem[i_copy][cnt[i_copy]] <= i_data;
        sd[i_copy][cnt[i_copy]]  <= i_side;
        cnt[i_copy]              <= cnt[i_copy] + 1;
        if (i_start) begin
          st_cp[n_st]  <= i_copy;
          st_cyc[n_st] <= cyc;
          n_st         <= n_st + 1;
        end
      end
    end
  end
endmodule // rtss_radio_sink

// [bench/rtss_scheduler_tb_top.sv]
/* Self-checking bench of the telegram scheduler.
   Assumes the radio sink model and the bound checker. */
`timescale 1ns/1ps
module rtss_scheduler_tb_top;
  localparam integer P = 100;  // Cycles per ms, shortened so runs stay brief
  reg         i_ref_clk = 1'b0, i_rst_b = 1'b0, i_tx_req = 1'b0, i_tx_compressed = 1'b0, i_tx_three = 1'b0;
  reg         i_tx_single = 1'b0, i_hop_hdr_en = 1'b0, i_long_type_en = 1'b0, i_src_long = 1'b0;
  reg         i_target_en = 1'b0, i_pay_valid = 1'b0, i_rx_valid = 1'b0, i_rx_compressed = 1'b0;
  reg         i_rx_has_target = 1'b0, stall = 1'b0, clr = 1'b0;
  reg  [1:0]  i_tx_rep_level = 2'h0;
  reg  [7:0]  i_header = 8'h5a, i_optional_hop_header = 8'h32, i_long_type_selector = 8'h44;
  reg  [7:0]  i_pay_data = 8'h00, i_rx_check = 8'h3c;
  reg  [4:0]  i_pay_len = 5'h01;
  reg  [47:0] i_source_id = 48'h112233445566, i_rx_source_id = 48'h0;
  reg  [31:0] i_target_id = 32'h8899aabb;
  wire        o_pay_ready, o_tx_valid, o_tx_start, o_tx_side, i_tx_ready, o_tx_busy, o_tx_mature;
  wire        o_tx_refused, o_rx_new, o_rx_dup, o_rx_addressed;
  wire [7:0]  o_tx_data;
  wire [1:0]  o_tx_copy;
  integer     num_errors = 0, checks_done = 0;
  // Windows per case and copy: frame, level 1, level 2, compressed 0 and 1, single
  integer     lo_t [0:17] = '{0, 1, 20, 10, 20, 0, 0, 20, 0, 0, 4, 14, 0, 4, 14, 0, 0, 0};
  integer     hi_t [0:17] = '{0, 9, 39, 19, 29, 0, 9, 29, 0, 1, 12, 22, 1, 12, 22, 0, 0, 0};
  integer     n_t [0:5] = '{3, 2, 2, 3, 2, 1};
  integer     lvl_t [0:5] = '{0, 1, 2, 0, 1, 0};
  localparam [5:0] CMP_V = 6'h18, THREE_V = 6'h19, ONE_V = 6'h20;
  always #2 i_ref_clk = ~i_ref_clk;
  rtss_scheduler #(.P_CYC_PER_MS(P)) uut (.*);
  rtss_radio_sink u_sink (.i_ref_clk, .i_rst_b, .i_stall(stall), .i_clr(clr), .i_valid(o_tx_valid),
    .i_data(o_tx_data), .i_start(o_tx_start), .i_side(o_tx_side), .i_copy(o_tx_copy), .o_ready(i_tx_ready));
  ////////////////////////////////////////////////////////////////////
  task chk(input [63:0] seen, input [63:0] exp, input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  // One byte into the FIFO, held until ready
  task push(input [7:0] b);
    begin
      @(negedge i_ref_clk);
      i_pay_valid = 1'b1;
      i_pay_data = b;
      while (o_pay_ready !== 1'b1) @(negedge i_ref_clk);
      @(negedge i_ref_clk);
      i_pay_valid = 1'b0;
    end
  endtask
  // Request case k, then judge timing, copies and maturity
  task tx_run(input integer k, input integer len);
    integer t0, c, j, x, ms, mat;
    begin
      @(negedge i_ref_clk);
      clr = 1'b1;
      i_tx_compressed = CMP_V[k];
      i_tx_rep_level = lvl_t[k][1:0];
      i_tx_three = THREE_V[k];
      i_tx_single = ONE_V[k];
      i_tx_req = 1'b1;
      @(negedge i_ref_clk);
      clr = 1'b0;
      i_tx_req = 1'b0;
      t0 = u_sink.cyc;
      mat = CMP_V[k] ? 25 : 40;
      j = 0;
      do begin
        @(negedge i_ref_clk);
        j = j + 1;
      end while (o_tx_mature !== 1'b1 && j < 50 * P);
      chk(j >= mat * P - 2 && j <= (mat + 1) * P, 1, "mature time");
      chk(u_sink.n_st, n_t[k], "copies");
      for (c = 0; c < n_t[k]; c = c + 1) begin
        ms = (u_sink.st_cyc[c] - t0) / P;
        chk(u_sink.st_cp[c], c, "copy index");
        chk(ms >= lo_t[3*k+c] && ms <= hi_t[3*k+c], 1, "offset");
        chk(u_sink.mem[c][0], len, "length");
        chk(u_sink.cnt[c], len, "byte count");
        x = 0;
        for (j = 0; j < len; j = j + 1) x = x ^ u_sink.mem[c][j];
        chk(x, 0, "check byte");
      end
    end
  endtask
  // Full frame after a FIFO filled to refusal, with a stalling sink
  task t_frame;
    reg [175:0] ev;
    integer i;
    begin
      stall = 1'b1;
      for (i = 1; i <= 8; i = i + 1) push(i[7:0]);
      @(negedge i_ref_clk);
      chk(o_pay_ready, 0, "fifo full");
      i_hop_hdr_en = 1'b1;
      i_long_type_en = 1'b1;
      i_src_long = 1'b1;
      i_target_en = 1'b1;
      i_pay_len = 5'h06;
      tx_run(0, 23);
      ev = {8'h17, i_header, i_optional_hop_header, i_long_type_selector, i_source_id, i_target_id,
            64'h0102030405060708};
      for (i = 0; i < 22; i = i + 1) begin
        chk(u_sink.mem[0][i], ev[175-8*i -: 8], "frame byte");
        chk(u_sink.sd[0][i], i >= 20, "side flag");
        chk(u_sink.mem[2][i], u_sink.mem[0][i], "copy match");
      end
      stall = 1'b0;
      i_hop_hdr_en = 1'b0;
      i_long_type_en = 1'b0;
      i_src_long = 1'b0;
      i_target_en = 1'b0;
      i_pay_len = 5'h01;
    end
  endtask
  // Repeater levels and the compressed profile
  task t_profiles;
    integer k;
    begin
      for (k = 1; k <= 4; k = k + 1) begin
        push(k[7:0]);
        tx_run(k, 8);
      end
    end
  endtask
  // Low-energy single copy, short source and no target
  task t_single;
    begin
      push(8'h99);
      tx_run(5, 8);
      chk(u_sink.mem[0][2], i_source_id[31:24], "short source");
      chk(u_sink.mem[0][6], 8'h99, "payload");
    end
  endtask
  // Compressed second-level repeat is dropped
  task t_refuse;
    begin
      @(negedge i_ref_clk);
      clr = 1'b1;
      i_tx_compressed = 1'b1;
      i_tx_rep_level = 2'h2;
      i_tx_req = 1'b1;
      @(negedge i_ref_clk);
      clr = 1'b0;
      i_tx_req = 1'b0;
      chk(o_tx_refused, 1, "refused");
      repeat (30 * P) @(negedge i_ref_clk);
      chk(u_sink.n_st, 0, "no copy");
    end
  endtask
  task rx_one(input [47:0] s, input t, input c, input nw);
    begin
      @(negedge i_ref_clk);
      i_rx_valid = 1'b1;
      i_rx_source_id = s;
      i_rx_has_target = t;
      i_rx_compressed = c;
      @(negedge i_ref_clk);
      i_rx_valid = 1'b0;
      chk(o_rx_new, nw, "rx new");
      chk(o_rx_dup, !nw, "rx dup");
      if (nw) chk(o_rx_addressed, t, "addressed");
    end
  endtask
  // Merge windows of both profiles, just inside and just past
  task t_rx;
    begin
      rx_one(48'ha1, 1'b1, 1'b0, 1'b1);
      repeat (95 * P) @(negedge i_ref_clk);
      rx_one(48'ha1, 1'b1, 1'b0, 1'b0);
      rx_one(48'hb2, 1'b0, 1'b0, 1'b1);
      repeat (105 * P) @(negedge i_ref_clk);
      rx_one(48'hb2, 1'b0, 1'b0, 1'b1);
      rx_one(48'hc3, 1'b1, 1'b1, 1'b1);
      repeat (45 * P) @(negedge i_ref_clk);
      rx_one(48'hc3, 1'b1, 1'b1, 1'b0);
      repeat (6 * P) @(negedge i_ref_clk);
      rx_one(48'hc3, 1'b1, 1'b1, 1'b1);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // Main sequence after twenty reset cycles
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    t_frame;
    t_profiles;
    t_single;
    t_refuse;
    t_rx;
    final_report;
  end
  // Watchdog: the sequence needs about 49000 cycles
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    num_errors = num_errors + 1;
    final_report;
  end
endmodule // rtss_scheduler_tb_top
